// ---- core/conv_ctl_cfg.svh ----
// constants for the conversion handshake block
// assumes a 40 MHz reference clock and pins crossing in asynchronously
`ifndef CONV_CTL_CFG_SVH
`define CONV_CTL_CFG_SVH
`define RESULT_W        12
`define EST_W           2
`define FLASH1_W        4
`define FLASH2_W        4
`define FLASH3_W        2
`define CLK_PERIOD_NS   25
`define CONV_TIME_NS    575
`define CONV_CYCLES     ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EOC_LOW_NS      100
`define EOC_LOW_CYCLES  ((`EOC_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W           8
`define RESULT_RST      12'h000
`endif

// ---- core/conv_ctl_pkg.sv ----
// types shared by the conversion handshake block
// assumes conv_ctl_cfg.svh is included first
`include "conv_ctl_cfg.svh"
package conv_ctl_pkg;
    typedef struct packed {
        logic [`EST_W-1:0]    est;
        logic [`FLASH1_W-1:0] flash1;
        logic [`FLASH2_W-1:0] flash2;
        logic [`FLASH3_W-1:0] flash3;
    } flash_codes_t;
    typedef struct packed {
        logic                 chan;
        logic [`RESULT_W-1:0] data;
    } conv_result_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_DONE
    } stage_state_t;
endpackage

// ---- core/result_buf.sv ----
// two-entry result buffer between conversion stages and the output latch
// assumes producer and consumer share i_ref_clk
`timescale 1ns/100ps
module result_buf
    import conv_ctl_pkg::*;
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire conv_result_t i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output conv_result_t      o_out_data
);
    conv_result_t mem_r [2];
    logic         wr_ptr_r;
    logic         rd_ptr_r;
    logic [1:0]   count_r;
    logic         push;
    logic         pop;

    assign o_in_ready  = (count_r != 2'h2);
    assign o_out_valid = (count_r != 2'h0);
    assign o_out_data  = mem_r[rd_ptr_r];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ---- core/conv_ctl.sv ----
// control logic of a pipelined two-stage 12-bit sampling converter
// assumes host strobes arrive asynchronously; flash codes come from
// the analog core and are stable while a stage converts
`timescale 1ns/100ps
`include "conv_ctl_cfg.svh"

// Summary of operation
// - a sample/hold fall with select low holds the input and converts it.
// - at conversion end the result is latched, done rises, pending falls.
// - a falling read strobe with select low returns the pending line high.
// - both strobes are ignored while the active-low select is high.
// - in high-speed mode with output enable high the latest result stays driven on the data bus.
// - two sampling stages alternate, one acquiring while the other converts.
// - the channel line is sampled as done falls and picks the input channel.
// - channel 0 routes analog input one, channel 1 analog input two.
// - each result joins the estimator and the three flash codes into 12 bits.
module conv_ctl
    import conv_ctl_pkg::*;
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_sample_hold,
    input  wire logic         i_dev_sel_n,
    input  wire logic         i_read_n,
    input  wire logic         i_out_en,
    input  wire logic         i_high_speed,
    input  wire logic         i_channel_select,
    input  wire flash_codes_t i_codes_a,
    input  wire flash_codes_t i_codes_b,
    output logic              o_hold_a,
    output logic              o_hold_b,
    output logic              o_mux_sel,
    output logic              o_conv_done,
    output logic              o_pending_n,
    output logic [`RESULT_W-1:0] o_data,
    output logic              o_data_oe,
    output logic              o_data_chan
);
    function automatic logic [`RESULT_W-1:0] join_codes(
        input flash_codes_t c
    );
        // estimator and first flash give the six msbs, then 4 + 2
        join_codes = {c.est, c.flash1, c.flash2, c.flash3};
    endfunction

    // last counted cycle of a conversion
    function automatic logic conv_last(
        input logic [`CNT_W-1:0] cnt
    );
        conv_last = (cnt == `CNT_W'(`CONV_CYCLES - 1));
    endfunction

    // counter step that parks on the last cycle
    function automatic logic [`CNT_W-1:0] cnt_step(
        input logic [`CNT_W-1:0] cnt
    );
        cnt_step = conv_last(cnt) ? cnt : cnt + `CNT_W'(1);
    endfunction

    // done has stayed low long enough once this is true
    function automatic logic eoc_last(
        input logic [`CNT_W-1:0] cnt
    );
        eoc_last = (cnt >= `CNT_W'(`EOC_LOW_CYCLES - 1));
    endfunction

    // a synchronised level that was high and is now low
    function automatic logic fell_edge(
        input logic older,
        input logic newer
    );
        fell_edge = older & ~newer;
    endfunction

    logic [2:0] sh_sync_r;
    logic [2:0] rd_sync_r;
    logic [1:0] cs_sync_r;
    logic [1:0] hs_sync_r;
    logic [1:0] oe_sync_r;
    logic [1:0] ch_sync_r;
    logic       sh_fall;
    logic       rd_fall;
    logic       sel;

    // first stage feeds only the second; edges come from stages 2 and 3
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sh_sync_r <= 3'h7;
            rd_sync_r <= 3'h7;
            cs_sync_r <= 2'h3;
            hs_sync_r <= 2'h0;
            oe_sync_r <= 2'h0;
            ch_sync_r <= 2'h0;
        end else begin
            sh_sync_r <= {sh_sync_r[1:0], i_sample_hold};
            rd_sync_r <= {rd_sync_r[1:0], i_read_n};
            cs_sync_r <= {cs_sync_r[0], i_dev_sel_n};
            hs_sync_r <= {hs_sync_r[0], i_high_speed};
            oe_sync_r <= {oe_sync_r[0], i_out_en};
            ch_sync_r <= {ch_sync_r[0], i_channel_select};
        end
    end

    assign sel     = ~cs_sync_r[1];
    assign sh_fall = sel & fell_edge(sh_sync_r[2], sh_sync_r[1]);
    assign rd_fall = sel & fell_edge(rd_sync_r[2], rd_sync_r[1]);

    stage_state_t           st_a_r;
    stage_state_t           st_b_r;
    logic [`CNT_W-1:0]      cnt_a_r;
    logic [`CNT_W-1:0]      cnt_b_r;
    logic                   chan_a_r;
    logic                   chan_b_r;
    logic                   start_a;
    logic                   start_b;
    logic                   next_stage_r;
    logic                   mux_sel_r;
    logic                   fin_a;
    logic                   fin_b;
    logic                   leave_a;
    logic                   leave_b;
    logic                   buf_in_ready;
    logic                   buf_in_valid;
    conv_result_t           buf_in_data;
    logic                   buf_out_valid;
    conv_result_t           buf_out_data;
    logic                   eoc_low_r;
    logic [`CNT_W-1:0]      eoc_cnt_r;
    logic                   take;

    // a trigger goes to the stage whose turn it is; a busy stage drops it
    // rather than queueing it, so a late conversion is never reported
    assign start_a = sh_fall && !next_stage_r && (st_a_r == ST_IDLE);
    assign start_b = sh_fall && next_stage_r && (st_b_r == ST_IDLE);

    // a stage done but refused by a full buffer waits in ST_DONE,
    // so a stalled output loses no word; stage a wins a tie
    assign fin_a        = (st_a_r == ST_DONE);
    assign fin_b        = (st_b_r == ST_DONE);
    assign buf_in_valid = fin_a | fin_b;
    assign leave_a      = fin_a && buf_in_ready;
    assign leave_b      = fin_b && buf_in_ready && !fin_a;
    always_comb begin
        buf_in_data.chan = fin_a ? chan_a_r : chan_b_r;
        buf_in_data.data = fin_a ? join_codes(i_codes_a)
                                 : join_codes(i_codes_b);
    end

    // stages alternate a, b, a
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            next_stage_r <= 1'b0;
        end else if (start_a || start_b) begin
            next_stage_r <= ~next_stage_r;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_a_r <= ST_IDLE;
        end else begin
            case (st_a_r)
                ST_IDLE: begin
                    if (start_a) begin
                        st_a_r <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_last(cnt_a_r)) begin
                        st_a_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (leave_a) begin
                        st_a_r <= ST_IDLE;
                    end
                end
                default: st_a_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_b_r <= ST_IDLE;
        end else begin
            case (st_b_r)
                ST_IDLE: begin
                    if (start_b) begin
                        st_b_r <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_last(cnt_b_r)) begin
                        st_b_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (leave_b) begin
                        st_b_r <= ST_IDLE;
                    end
                end
                default: st_b_r <= ST_IDLE;
            endcase
        end
    end

    // counters restart when their own stage takes a trigger and park on the last cycle
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_a_r <= '0;
        end else if (start_a) begin
            cnt_a_r <= '0;
        end else if (st_a_r == ST_CONV) begin
            cnt_a_r <= cnt_step(cnt_a_r);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_b_r <= '0;
        end else if (start_b) begin
            cnt_b_r <= '0;
        end else if (st_b_r == ST_CONV) begin
            cnt_b_r <= cnt_step(cnt_b_r);
        end
    end

    // the held sample came through the channel picked at the last done
    // fall, so a stage keeps the mux setting from before its trigger
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            chan_a_r <= 1'b0;
            chan_b_r <= 1'b0;
        end else begin
            if (start_a) begin
                chan_a_r <= mux_sel_r;
            end
            if (start_b) begin
                chan_b_r <= mux_sel_r;
            end
        end
    end

    assign o_hold_a = (st_a_r != ST_IDLE);
    assign o_hold_b = (st_b_r != ST_IDLE);

    result_buf u_buf (
        .i_ref_clk   (i_ref_clk),
        .i_nrst      (i_nrst),
        .i_in_valid  (buf_in_valid),
        .o_in_ready  (buf_in_ready),
        .i_in_data   (buf_in_data),
        .o_out_valid (buf_out_valid),
        .i_out_ready (take),
        .o_out_data  (buf_out_data)
    );

    // done falls at each sample hold edge, then rises with the next result
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            eoc_low_r <= 1'b0;
            eoc_cnt_r <= '0;
        end else if (sh_fall) begin
            eoc_low_r <= 1'b1;
            eoc_cnt_r <= '0;
        end else if (eoc_low_r && buf_out_valid) begin
            if (eoc_last(eoc_cnt_r)) begin
                eoc_low_r <= 1'b0;
            end else begin
                eoc_cnt_r <= eoc_cnt_r + `CNT_W'(1);
            end
        end
    end

    logic conv_done_r;
    logic pending_n_r;
    logic [`RESULT_W-1:0] data_r;
    logic data_chan_r;

    // the buffer is popped only here, so no word leaves it unlatched
    assign take = eoc_low_r && buf_out_valid && eoc_last(eoc_cnt_r) &&
                  !sh_fall;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            conv_done_r <= 1'b0;
            data_r      <= `RESULT_RST;
            data_chan_r <= 1'b0;
        end else if (take) begin
            conv_done_r <= 1'b1;
            data_r      <= buf_out_data.data;
            data_chan_r <= buf_out_data.chan;
        end else if (sh_fall) begin
            conv_done_r <= 1'b0;
        end
    end

    // new result wins over a read in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pending_n_r <= 1'b1;
        end else if (take) begin
            pending_n_r <= 1'b0;
        end else if (rd_fall) begin
            pending_n_r <= 1'b1;
        end
    end

    // channel taken on done falling; 0 picks input one, 1 input two
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mux_sel_r <= 1'b0;
        end else if (conv_done_r && !take && sh_fall) begin
            mux_sel_r <= ch_sync_r[1];
        end
    end

    assign o_mux_sel   = mux_sel_r;
    assign o_conv_done = conv_done_r;
    assign o_pending_n = pending_n_r;
    assign o_data      = data_r;
    assign o_data_chan = data_chan_r;
    // with output enable high, high-speed mode keeps the bus driven; else host holds select and read low
    assign o_data_oe   = oe_sync_r[1] &&
                         (hs_sync_r[1] || (sel && !rd_sync_r[2]));
endmodule

// ---- sim/conv_ctl_monitor.sv ----
// checker for the conversion handshake block
// assumes it is bound onto conv_ctl and sees its ports only
`timescale 1ns/100ps
module conv_ctl_monitor (
    input wire logic        i_ref_clk,
    input wire logic        i_nrst,
    input wire logic        i_dev_sel_n,
    input wire logic        i_read_n,
    input wire logic        i_out_en,
    input wire logic        i_high_speed,
    input wire logic        i_channel_select,
    input wire logic        o_hold_a,
    input wire logic        o_hold_b,
    input wire logic        o_mux_sel,
    input wire logic        o_conv_done,
    input wire logic        o_pending_n,
    input wire logic [11:0] o_data,
    input wire logic        o_data_oe
);
    logic [3:0] sel_hi_r;
    logic       last_b_r;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // saturates so a long deselect cannot wrap back to zero
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) sel_hi_r <= 4'h0;
        else if (!i_dev_sel_n) sel_hi_r <= 4'h0;
        else if (sel_hi_r != 4'hF) sel_hi_r <= sel_hi_r + 4'h1;
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) last_b_r <= 1'b1;
        else if ($rose(o_hold_a)) last_b_r <= 1'b0;
        else if ($rose(o_hold_b)) last_b_r <= 1'b1;
    end
    done_pend_a:
        assert property ($rose(o_conv_done) |-> !o_pending_n)
        else $error("pending not low with done");
    eoc_low_a:
        assert property ($fell(o_conv_done) |-> (!o_conv_done)[*4])
        else $error("done low too short");
    read_clear_a:
        assert property (($fell(i_read_n) && !i_dev_sel_n && !o_pending_n)
            |-> ##[1:5] o_pending_n)
        else $error("read did not clear pending");
    sel_gate_a:
        assert property (($rose(o_hold_a) || $rose(o_hold_b))
            |-> sel_hi_r < 4'h6)
        else $error("conversion started while deselected");
    alt_to_a_a:
        assert property ($rose(o_hold_a) |-> last_b_r)
        else $error("stage a used twice");
    alt_to_b_a:
        assert property ($rose(o_hold_b) |-> !last_b_r)
        else $error("stage b used twice");
    mux_pick_a:
        assert property ($fell(o_conv_done)
            |-> ##[0:4] (o_mux_sel == i_channel_select))
        else $error("channel not taken");
    hs_drive_a:
        assert property ((i_high_speed && i_out_en)[*4] |-> o_data_oe)
        else $error("bus not driven in fast mode");
    data_hold_a:
        assert property (!$stable(o_data) |-> o_conv_done)
        else $error("data changed without a result");
endmodule
bind conv_ctl conv_ctl_monitor mon (
    .i_ref_clk, .i_nrst, .i_dev_sel_n, .i_read_n, .i_out_en,
    .i_high_speed, .i_channel_select, .o_hold_a, .o_hold_b, .o_mux_sel,
    .o_conv_done, .o_pending_n, .o_data, .o_data_oe
);

// ---- sim/host_model.sv ----
// host side model: answers a pending result with a read strobe
// assumes the strobe is launched on the falling clock edge
`timescale 1ns/100ps
module host_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_en,
    input  wire logic       i_hs,
    input  wire logic [3:0] i_wait,
    input  wire logic       i_pending_n,
    output logic            o_read_n
);
    logic [3:0] cnt_r = 4'h0;
    initial o_read_n = 1'b1;
    // read held until the answer, so a slow sync never misses it
    always @(negedge i_ref_clk) begin
        if (i_hs) o_read_n <= 1'b0;
        else if (!o_read_n) begin
            if (i_pending_n) o_read_n <= 1'b1;
        end else if (i_en && !i_pending_n) begin
            if (cnt_r == i_wait) begin
                o_read_n <= 1'b0;
                cnt_r <= 4'h0;
            end else cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule

// ---- sim/conv_ctl_test.sv ----
// self-checking bench for the conversion handshake block
// assumes host_model answers reads; inputs change on falling edges
`timescale 1ns/100ps
module conv_ctl_test;
    import conv_ctl_pkg::*;
    logic         i_ref_clk = 1'b0, i_nrst = 1'b0, i_sample_hold = 1'b1;
    logic         i_dev_sel_n = 1'b1, i_out_en = 1'b0, i_high_speed = 1'b0;
    logic         i_channel_select = 1'b0, en = 1'b0, i_read_n;
    logic [3:0]   wt = 4'h0;
    flash_codes_t i_codes_a = 12'h5A3, i_codes_b = 12'hC3E;
    logic         o_hold_a, o_hold_b, o_mux_sel, o_conv_done;
    logic         o_pending_n, o_data_oe, o_data_chan;
    logic [11:0]  o_data;
    int           n_fail = 0, n_checks = 0;
    always #12.5 i_ref_clk = ~i_ref_clk;
    conv_ctl uut (.i_ref_clk, .i_nrst, .i_sample_hold, .i_dev_sel_n,
        .i_read_n, .i_out_en, .i_high_speed, .i_channel_select,
        .i_codes_a, .i_codes_b, .o_hold_a, .o_hold_b, .o_mux_sel,
        .o_conv_done, .o_pending_n, .o_data, .o_data_oe, .o_data_chan);
    host_model host (.i_ref_clk, .i_en(en), .i_hs(i_high_speed),
        .i_wait(wt), .i_pending_n(o_pending_n), .o_read_n(i_read_n));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic sample(input logic ch);
        @(negedge i_ref_clk);
        i_channel_select = ch;
        i_sample_hold = 1'b0;
        repeat (4) @(negedge i_ref_clk);
        i_sample_hold = 1'b1;
    endtask
    task automatic wait_for(ref logic s, input logic v);
        for (int k = 0; k < 80 && s !== v; k++) @(negedge i_ref_clk);
    endtask
    task automatic t_select;
        sample(1'b0);
        repeat (30) @(negedge i_ref_clk);
        chk(12'({o_hold_a, o_hold_b}), 12'h000);
        chk(12'(o_pending_n), 12'h001);
        i_dev_sel_n = 1'b0;
        $display("t_select finished");
    endtask
    task automatic t_conv;
        en = 1'b1;
        i_out_en = 1'b1;
        sample(1'b0);
        wait_for(o_pending_n, 1'b0);
        chk(o_data, 12'(i_codes_a));
        chk(12'(o_conv_done), 12'h001);
        chk(12'({o_mux_sel, o_data_chan}), 12'h000);
        chk(12'(o_data_oe), 12'h000);
        wait_for(o_pending_n, 1'b1);
        chk(12'(o_pending_n), 12'h001);
        chk(12'(o_data_oe), 12'h001);
        wt = 4'h8;
        sample(1'b1);
        wait_for(o_pending_n, 1'b0);
        chk(o_data, 12'(i_codes_b));
        // new channel applies from the next sample, not the held one
        chk(12'({o_mux_sel, o_data_chan}), 12'h002);
        wait_for(o_pending_n, 1'b1);
        chk(12'(o_pending_n), 12'h001);
        $display("t_conv finished");
    endtask
    task automatic t_hs;
        en = 1'b0;
        i_high_speed = 1'b1;
        i_out_en = 1'b1;
        sample(1'b0);
        wait_for(o_conv_done, 1'b1);
        chk(o_data, 12'(i_codes_a));
        chk(12'({o_data_oe, o_mux_sel, o_data_chan}), 12'h005);
        $display("t_hs finished");
    endtask
    task automatic end_sim;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // the tests need about 160 cycles; allow well over twenty times that
    initial begin
        #(25 * 4000);
        n_fail++;
        end_sim;
    end
    initial begin
        repeat (4) @(negedge i_ref_clk);
        i_nrst = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        t_select;
        t_conv;
        t_hs;
        end_sim;
    end
endmodule
